// ==== tb.sv ====
// Self-checking testbench for the configuration and power-mode block
`timescale 1ns/1ps
module tb
  import tcpm_pkg::*;
;
  logic       clk_sys, rst_n, chip_power_enable, tx_rx_select;
  logic [4:0] gain_pins, tx_gain_eff, rf_int_coarse, if_int_coarse;
  logic       ser_clk, ser_data, ser_enable;
  tcpm_mode_t power_mode;
  logic       clk_out_on, osc_on, serial_on, rf_pll_on, if_pll_on, tx_on;
  logic       rx_on, band_a_sel, spectral_invert, ref_divider_select;
  logic       if_frac_mode, charge_pump_cont, osc_low_power, if_amp_linearity;
  logic [2:0] rf_int_offset, if_int_offset;
  logic [6:0] rf_numerator, rf_modulus, if_numerator, if_modulus;
  int         bad_count, checked, seed, v;
  int         regs [8];
  localparam int DEFS [8] = '{0, 0, 'h80, 0, 'hb0, 'hcf, 'h50, 'h40};

  tcpm_config dut_u (.*);
  tcpm_host host_u (.*);

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  function automatic int rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic cmp(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Compares every output with the register model
  task automatic check_all();
    int md;
    logic fr;
    logic [6:0] em;
    logic [21:0] ef;
    md = !chip_power_enable ? 0 : !regs[2][0] ? 1 : regs[2][1] ? 3 : 2;
    fr = regs[2][4] && md >= 2;
    em = {{3{chip_power_enable}}, md >= 2, md >= 2, md == 3 && tx_rx_select,
          md == 3 && !tx_rx_select};
    ef = fr ? {regs[3][7:0], regs[0][6:0], regs[1][6:0]} : 22'h0;
    cmp(power_mode, md);
    cmp({clk_out_on, osc_on, serial_on, rf_pll_on, if_pll_on, tx_on,
         rx_on}, em);
    cmp({band_a_sel, spectral_invert, charge_pump_cont, osc_low_power,
         if_amp_linearity}, {regs[2][2], regs[7][6], regs[7][7], regs[4][7],
         regs[2][6]});
    cmp({ref_divider_select, rf_int_coarse, rf_int_offset, rf_numerator,
         rf_modulus}, {regs[5][7], regs[6][7:0], regs[4][6:0],
         regs[5][6:0]});
    cmp({if_frac_mode, if_int_coarse, if_int_offset, if_numerator,
         if_modulus}, {fr, ef});
    cmp(tx_gain_eff, regs[2][7] ? gain_pins : regs[7][4:0]);
  endtask

  task automatic wr(input int idx, input int d, input int slow);
    d &= (idx == 2 || idx == 7) ? 'hdf : 'hff;
    host_u.send({d[7:0], 8'hd8 + 8'(idx)}, slow);
    if (chip_power_enable && idx < 8)
      regs[idx] = d;
    repeat (4) @(negedge clk_sys);
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    bad_count++;
    complete_run();
  end

  initial begin
    seed = 69082;
    bad_count = 0;
    checked = 0;
    rst_n = 1'b0;
    chip_power_enable = 1'b1;
    tx_rx_select = 1'b0;
    gain_pins = 5'h0a;
    regs = DEFS;
    repeat (10) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (2) @(negedge clk_sys);
    check_all();
    $display("Test defaults done");
    for (int r = 0; r < 40; r++) begin
      v = rnd();
      gain_pins = v[4:0];
      tx_rx_select = v[8];
      wr(r % 9, v >> 12, r % 2);
      check_all();
    end
    $display("Test random writes done");
    for (int p = 0; p < 8; p++) begin
      tx_rx_select = p[2];
      wr(2, 'h10 | (p & 3), 0);
      check_all();
    end
    $display("Test power modes done");
    v = rnd();
    gain_pins = v[4:0];
    chip_power_enable = 1'b0;
    regs = DEFS;
    wr(5, 'h12, 0);
    check_all();
    chip_power_enable = 1'b1;
    repeat (2) @(negedge clk_sys);
    check_all();
    wr(5, 'h55, 1);
    check_all();
    rst_n = 1'b0;
    regs = DEFS;
    repeat (2) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (2) @(negedge clk_sys);
    check_all();
    $display("Test power enable and reset done");
    complete_run();
  end
endmodule

// ==== tcpm_chk.sv ====
// Assertions on the configuration and power-mode block
`timescale 1ns/1ps
module tcpm_chk
  import tcpm_pkg::*;
(
  // Clock and reset
  input wire logic       clk_sys,
  input wire logic       rst_n,
  // Pins
  input wire logic       chip_power_enable,
  input wire logic       tx_rx_select,
  input wire logic [4:0] gain_pins,
  input wire logic       ser_enable,
  // Mode outputs
  input wire tcpm_mode_t power_mode,
  input wire logic       serial_on,
  input wire logic       rf_pll_on,
  input wire logic       if_pll_on,
  input wire logic       tx_on,
  input wire logic       rx_on,
  // Field outputs
  input wire logic       band_a_sel,
  input wire logic [4:0] tx_gain_eff,
  input wire logic       spectral_invert,
  input wire logic [4:0] rf_int_coarse,
  input wire logic [6:0] rf_numerator,
  input wire logic [6:0] rf_modulus,
  input wire logic       if_frac_mode,
  input wire logic [4:0] if_int_coarse,
  input wire logic [6:0] if_modulus,
  input wire logic       osc_low_power
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  AST_SLEEP: assert property (
    !chip_power_enable |-> power_mode == TCPM_SLEEP && !serial_on && !rf_pll_on)
    else $error("Sleep not decoded");
  AST_STANDBY: assert property (
    power_mode == TCPM_STANDBY |-> serial_on && !rf_pll_on && !if_pll_on)
    else $error("Standby outputs wrong");
  AST_ACTIVE: assert property (
    power_mode == TCPM_ACTIVE |-> tx_on == tx_rx_select && rx_on != tx_on)
    else $error("Active direction wrong");
  AST_NOT_ACTIVE: assert property (
    power_mode != TCPM_ACTIVE |-> !tx_on && !rx_on)
    else $error("Radio on outside active");
  AST_PE_RELOAD: assert property (
    !chip_power_enable |=> spectral_invert && osc_low_power && !band_a_sel
      && rf_modulus == 7'h4f && rf_int_coarse == 5'h0a)
    else $error("Defaults not reloaded");
  AST_RST_DEF: assert property (
    $rose(rst_n) |-> rf_numerator == 7'h30 && rf_modulus == 7'h4f)
    else $error("Reset values wrong");
  AST_IF_GATE: assert property (
    !if_frac_mode |-> if_int_coarse == 5'h00 && if_modulus == 7'h00)
    else $error("IF word leaks");
  AST_FRAC_MODE: assert property (
    if_frac_mode |-> power_mode inside {TCPM_IDLE, TCPM_ACTIVE})
    else $error("Fractional outside idle");
  AST_GAIN_PINS: assert property (
    !chip_power_enable ##1 !chip_power_enable |=> tx_gain_eff == $past(gain_pins))
    else $error("Gain pins not routed");
  AST_HOLD: assert property (
    ser_enable && $past(ser_enable) && chip_power_enable
      && $past(chip_power_enable) |=> $stable(rf_modulus) && $stable(band_a_sel))
    else $error("Field changed without commit");
endmodule

bind tcpm_config tcpm_chk chk_u (.*);

// ==== tcpm_config.sv ====
// Serial configuration fields and power-mode decode of the transceiver
//
// Function
// [R01] Two-bit power state field resets to zero, picks standby, idle, active.
// [R02] Band select resets zero; one picks band A, zero band B.
// [R03] Five-bit serial gain level drives transmit gain when source is serial.
// [R04] Spectral invert defaults one, inverts both modulator and demodulator.
// [R05] Reference divider select defaults one, sets reference predivider.
// [R06] RF synthesizer words reset to 10, 0, 48 and 79.
// [R07] IF synthesizer words take effect only with fractional enable set.
// [R08] Gain source defaults one; one picks parallel pins, zero serial field.
// [R09] Fractional enable defaults zero; clear gives fixed low-power IF.
// [R10] Controller always writes zero to both reserved reference bits.
// [R11] Charge pump bit defaults zero; one gives continuous current mode.
// [R12] Oscillator low-power bit defaults one; zero gives full power.
// [R13] IF amplifier linearity bit defaults zero; front end untouched.
// [R14] All fields reload defaults at reset and when power enable rises.
// [R15] Both power bits set gives active; tx_rx_select picks transmit.
// [R16] Standby: clock, oscillator, serial on; idle adds PLLs; sleep all off.
// [R17] Sixteen-bit word, MSB first, data byte high, address byte low.
`timescale 1ns/1ps

module tcpm_config
  import tcpm_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  // Chip pins
  input  wire logic       chip_power_enable,
  input  wire logic       tx_rx_select,
  input  wire logic [4:0] gain_pins,
  // Three-wire serial port, sampled on clk_sys
  input  wire logic       ser_clk,
  input  wire logic       ser_data,
  input  wire logic       ser_enable,
  // Decoded mode
  output tcpm_mode_t      power_mode,
  output logic            clk_out_on,
  output logic            osc_on,
  output logic            serial_on,
  output logic            rf_pll_on,
  output logic            if_pll_on,
  output logic            tx_on,
  output logic            rx_on,
  // Field outputs
  output logic            band_a_sel,
  output logic [4:0]      tx_gain_eff,
  output logic            spectral_invert,
  output logic            ref_divider_select,
  output logic [4:0]      rf_int_coarse,
  output logic [2:0]      rf_int_offset,
  output logic [6:0]      rf_numerator,
  output logic [6:0]      rf_modulus,
  output logic            if_frac_mode,
  output logic [4:0]      if_int_coarse,
  output logic [2:0]      if_int_offset,
  output logic [6:0]      if_numerator,
  output logic [6:0]      if_modulus,
  output logic            charge_pump_cont,
  output logic            osc_low_power,
  output logic            if_amp_linearity
);

  // ==========================================================
  // Field storage
  logic [1:0]  power_state_sel_ff;
  logic        band_select_ff;
  logic [4:0]  tx_gain_level_ff;
  logic        spectral_invert_ff;
  logic        ref_divider_select_ff;
  logic [4:0]  rf_int_coarse_ff;
  logic [2:0]  rf_int_offset_ff;
  logic [6:0]  rf_numerator_ff;
  logic [6:0]  rf_modulus_ff;
  logic [4:0]  if_int_coarse_ff;
  logic [2:0]  if_int_offset_ff;
  logic [6:0]  if_numerator_ff;
  logic [6:0]  if_modulus_ff;
  logic        tx_gain_source_ff;
  logic        if_fractional_enable_ff;
  logic        reserved_zero_a_ff;
  logic        reserved_zero_b_ff;
  logic        charge_pump_cont_ff;
  logic        osc_low_power_ff;
  logic        if_amp_linearity_ff;
  logic [4:0]  gain_eff_ff;

  // ==========================================================
  // Serial shifter
  logic                  ser_clk_ff;
  logic                  pe_ff;
  logic [WORD_BITS-1:0]  shift_ff;
  logic [WORD_BITS-1:0]  nxt_shift;
  logic                  write_stb;
  logic                  load_dflt;
  logic [7:0]            wr_addr;
  logic [7:0]            wr_data;

  // Low power enable holds defaults; rising edge reloads them
  assign load_dflt = !chip_power_enable || (chip_power_enable && !pe_ff);

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pe_ff      <= 1'b0;
      ser_clk_ff <= 1'b0;
    end else begin
      pe_ff      <= chip_power_enable;
      ser_clk_ff <= ser_clk;
    end
  end

  // Shift on rising serial clock while enable low, MSB first
  always_comb begin
    nxt_shift = shift_ff;
    if (!ser_enable && ser_clk && !ser_clk_ff) begin
      nxt_shift = {shift_ff[WORD_BITS-2:0], ser_data}; // see [R17]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n || !chip_power_enable) begin
      shift_ff <= '0;
    end else begin
      shift_ff <= nxt_shift;
    end
  end

  // Word latched when enable returns high
  logic ser_en_ff;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ser_en_ff <= 1'b1;
    end else begin
      ser_en_ff <= ser_enable;
    end
  end

  assign write_stb = ser_enable && !ser_en_ff && chip_power_enable;
  assign wr_addr   = shift_ff[ADDR_LSB +: 8]; // see [R17]
  assign wr_data   = shift_ff[DATA_LSB +: 8]; // see [R17]

  // ==========================================================
  // Field writes
  logic  wr_ctrl;
  logic  wr_gain;
  logic  wr_rfmod;
  logic  wr_rfnum;
  logic  wr_rfint;
  logic  wr_ifint;
  logic  wr_ifnum;
  logic  wr_ifmod;

  assign wr_ctrl  = write_stb && (wr_addr == ADDR_CTRL);
  assign wr_gain  = write_stb && (wr_addr == ADDR_GAIN);
  assign wr_rfmod = write_stb && (wr_addr == ADDR_RFMOD);
  assign wr_rfnum = write_stb && (wr_addr == ADDR_RFNUM);
  assign wr_rfint = write_stb && (wr_addr == ADDR_RFINT);
  assign wr_ifint = write_stb && (wr_addr == ADDR_IFINT);
  assign wr_ifnum = write_stb && (wr_addr == ADDR_IFNUM);
  assign wr_ifmod = write_stb && (wr_addr == ADDR_IFMOD);

  always_ff @(posedge clk_sys) begin
    if (!rst_n || load_dflt) begin // see [R14]
      power_state_sel_ff <= RST_PS; // see [R01]
    end else if (wr_ctrl) begin
      power_state_sel_ff <= wr_data[POS_PS +: 2];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n || load_dflt) begin
      band_select_ff <= RST_BAND; // see [R02]
    end else if (wr_ctrl) begin
      band_select_ff <= wr_data[POS_BAND];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n || load_dflt) begin
      if_fractional_enable_ff <= RST_FNIF; // see [R09]
    end else if (wr_ctrl) begin
      if_fractional_enable_ff <= wr_data[POS_FNIF];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n || load_dflt) begin
      reserved_zero_a_ff <= RST_REFZ;
    end else if (wr_ctrl) begin
      reserved_zero_a_ff <= wr_data[POS_REFA]; // see [R10]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n || load_dflt) begin
      if_amp_linearity_ff <= RST_AMPLIN; // see [R13]
    end else if (wr_ctrl) begin
      if_amp_linearity_ff <= wr_data[POS_AMPLIN];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n || load_dflt) begin
      tx_gain_source_ff <= RST_GSRC; // see [R08]
    end else if (wr_ctrl) begin
      tx_gain_source_ff <= wr_data[POS_GSRC];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n || load_dflt) begin
      tx_gain_level_ff <= RST_GAIN;
    end else if (wr_gain) begin
      tx_gain_level_ff <= wr_data[POS_GAIN +: 5]; // see [R03]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n || load_dflt) begin
      reserved_zero_b_ff <= RST_REFZ;
    end else if (wr_gain) begin
      reserved_zero_b_ff <= wr_data[POS_REFB];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n || load_dflt) begin
      spectral_invert_ff <= RST_SINV; // see [R04]
    end else if (wr_gain) begin
      spectral_invert_ff <= wr_data[POS_SINV];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n || load_dflt) begin
      charge_pump_cont_ff <= RST_CP; // see [R11]
    end else if (wr_gain) begin
      charge_pump_cont_ff <= wr_data[POS_CP];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n || load_dflt) begin
      rf_modulus_ff <= RST_RFMOD; // see [R06]
    end else if (wr_rfmod) begin
      rf_modulus_ff <= wr_data[POS_MOD +: 7];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n || load_dflt) begin
      ref_divider_select_ff <= RST_REFDIV; // see [R05]
    end else if (wr_rfmod) begin
      ref_divider_select_ff <= wr_data[POS_REFDIV];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n || load_dflt) begin
      rf_numerator_ff <= RST_RFNUM; // see [R06]
    end else if (wr_rfnum) begin
      rf_numerator_ff <= wr_data[POS_MOD +: 7];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n || load_dflt) begin
      osc_low_power_ff <= RST_OSCLP; // see [R12]
    end else if (wr_rfnum) begin
      osc_low_power_ff <= wr_data[POS_OSCLP];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n || load_dflt) begin
      rf_int_coarse_ff <= RST_RFCRS; // see [R06]
    end else if (wr_rfint) begin
      rf_int_coarse_ff <= wr_data[POS_COARSE +: 5];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n || load_dflt) begin
      rf_int_offset_ff <= RST_RFOFS;
    end else if (wr_rfint) begin
      rf_int_offset_ff <= wr_data[POS_OFS +: 3];
    end
  end

  // IF words have no defined default; cleared to a known value
  always_ff @(posedge clk_sys) begin
    if (!rst_n || load_dflt) begin
      if_int_coarse_ff <= RST_IFCRS;
    end else if (wr_ifint) begin
      if_int_coarse_ff <= wr_data[POS_COARSE +: 5];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n || load_dflt) begin
      if_int_offset_ff <= RST_IFOFS;
    end else if (wr_ifint) begin
      if_int_offset_ff <= wr_data[POS_OFS +: 3];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n || load_dflt) begin
      if_numerator_ff <= RST_IFNUM;
    end else if (wr_ifnum) begin
      if_numerator_ff <= wr_data[POS_MOD +: 7];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n || load_dflt) begin
      if_modulus_ff <= RST_IFMOD;
    end else if (wr_ifmod) begin
      if_modulus_ff <= wr_data[POS_MOD +: 7];
    end
  end

  // ==========================================================
  // Transmit gain mux
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      gain_eff_ff <= RST_GAIN;
    end else if (tx_gain_source_ff) begin
      gain_eff_ff <= gain_pins; // see [R08]
    end else begin
      gain_eff_ff <= tx_gain_level_ff; // see [R03]
    end
  end

  // ==========================================================
  // Power mode decode
  always_comb begin
    if (!chip_power_enable) begin
      power_mode = TCPM_SLEEP; // see [R16]
    end else if (!power_state_sel_ff[0]) begin
      power_mode = TCPM_STANDBY; // see [R16]
    end else if (!power_state_sel_ff[1]) begin
      power_mode = TCPM_IDLE; // see [R16]
    end else begin
      power_mode = TCPM_ACTIVE; // see [R15]
    end
  end

  assign serial_on  = (power_mode != TCPM_SLEEP);
  assign osc_on     = serial_on;
  assign clk_out_on = serial_on;
  assign rf_pll_on  = (power_mode == TCPM_IDLE) ||
                      (power_mode == TCPM_ACTIVE); // see [R16]
  assign if_pll_on  = rf_pll_on;
  assign tx_on      = (power_mode == TCPM_ACTIVE) && tx_rx_select;  // see [R15]
  assign rx_on      = (power_mode == TCPM_ACTIVE) && !tx_rx_select; // see [R15]

  // ==========================================================
  // Field outputs
  assign band_a_sel         = band_select_ff; // see [R02]
  assign tx_gain_eff        = gain_eff_ff;
  assign spectral_invert    = spectral_invert_ff;
  assign ref_divider_select = ref_divider_select_ff;
  assign rf_int_coarse      = rf_int_coarse_ff;
  assign rf_int_offset      = rf_int_offset_ff;
  assign rf_numerator       = rf_numerator_ff;
  assign rf_modulus         = rf_modulus_ff;
  assign if_frac_mode       = if_fractional_enable_ff && rf_pll_on; // see [R09]
  // IF words reach the synthesizer only in fractional mode
  assign if_int_coarse = if_frac_mode ? if_int_coarse_ff : '0; // see [R07]
  assign if_int_offset = if_frac_mode ? if_int_offset_ff : '0; // see [R07]
  assign if_numerator  = if_frac_mode ? if_numerator_ff  : '0; // see [R07]
  assign if_modulus    = if_frac_mode ? if_modulus_ff    : '0; // see [R07]
  assign charge_pump_cont   = charge_pump_cont_ff;
  assign osc_low_power      = osc_low_power_ff;
  assign if_amp_linearity   = if_amp_linearity_ff;

endmodule

// ==== tcpm_host.sv ====
// Baseband controller model driving the three-wire serial port
`timescale 1ns/1ps
module tcpm_host (
  // Clock
  input  wire logic clk_sys,
  // Serial port
  output logic      ser_clk,
  output logic      ser_data,
  output logic      ser_enable
);
  initial begin
    ser_clk = 1'b0;
    ser_data = 1'b0;
    ser_enable = 1'b1;
  end
  // One word MSB first, data byte then address byte
  task automatic send(input logic [15:0] word, input int slow);
    @(negedge clk_sys);
    ser_enable = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      ser_data = word[i];
      repeat (2 + slow) @(negedge clk_sys);
      ser_clk = 1'b1;
      repeat (2 + slow) @(negedge clk_sys);
      ser_clk = 1'b0;
    end
    ser_enable = 1'b1;
    ser_data = ~ser_data;
  endtask
endmodule

// ==== tcpm_pkg.sv ====
// Package for the transceiver configuration and power-mode block
package tcpm_pkg;

  // ==========================================================
  // Serial word layout
  localparam int WORD_BITS  = 16;
  localparam int ADDR_LSB   = 0;
  localparam int DATA_LSB   = 8;

  // ==========================================================
  // Register address codes
  localparam logic [7:0] ADDR_CTRL   = 8'hda;
  localparam logic [7:0] ADDR_GAIN   = 8'hdf;
  localparam logic [7:0] ADDR_RFMOD  = 8'hdd;
  localparam logic [7:0] ADDR_IFNUM  = 8'hd8;
  localparam logic [7:0] ADDR_IFMOD  = 8'hd9;
  localparam logic [7:0] ADDR_IFINT  = 8'hdb;
  localparam logic [7:0] ADDR_RFNUM  = 8'hdc;
  localparam logic [7:0] ADDR_RFINT  = 8'hde;

  // ==========================================================
  // Field positions within the data byte
  localparam int POS_PS      = 0;
  localparam int POS_BAND    = 2;
  localparam int POS_FNIF    = 4;
  localparam int POS_REFA    = 5;
  localparam int POS_AMPLIN  = 6;
  localparam int POS_GSRC    = 7;
  localparam int POS_GAIN    = 0;
  localparam int POS_REFB    = 5;
  localparam int POS_SINV    = 6;
  localparam int POS_CP      = 7;
  localparam int POS_MOD     = 0;
  localparam int POS_REFDIV  = 7;
  localparam int POS_OSCLP   = 7;
  localparam int POS_OFS     = 0;
  localparam int POS_COARSE  = 3;

  // ==========================================================
  // Reset values
  localparam logic [1:0] RST_PS      = 2'h0;
  localparam logic       RST_BAND    = 1'h0;
  localparam logic [4:0] RST_GAIN    = 5'h00;
  localparam logic       RST_SINV    = 1'h1;
  localparam logic       RST_REFDIV  = 1'h1;
  localparam logic [4:0] RST_RFCRS   = 5'h0a;
  localparam logic [2:0] RST_RFOFS   = 3'h0;
  localparam logic [6:0] RST_RFNUM   = 7'h30;
  localparam logic [6:0] RST_RFMOD   = 7'h4f;
  localparam logic [4:0] RST_IFCRS   = 5'h00;
  localparam logic [2:0] RST_IFOFS   = 3'h0;
  localparam logic [6:0] RST_IFNUM   = 7'h00;
  localparam logic [6:0] RST_IFMOD   = 7'h00;
  localparam logic       RST_GSRC    = 1'h1;
  localparam logic       RST_FNIF    = 1'h0;
  localparam logic       RST_REFZ    = 1'h0;
  localparam logic       RST_CP      = 1'h0;
  localparam logic       RST_OSCLP   = 1'h1;
  localparam logic       RST_AMPLIN  = 1'h0;

  // ==========================================================
  // Power modes
  typedef enum logic [1:0] {
    TCPM_SLEEP,
    TCPM_STANDBY,
    TCPM_IDLE,
    TCPM_ACTIVE
  } tcpm_mode_t;

endpackage
